// file: include/iface_pkg.sv
// constants shared by the instrument bus interface controller
package iface_pkg;
  // apb register byte offsets
  localparam int         APB_AW       = 8;
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_ROM_ADDR = 8'h08;
  localparam logic [7:0] REG_ROM_DATA = 8'h0c;
  localparam logic [7:0] REG_STORE_LO = 8'h10;
  localparam logic [7:0] REG_STORE_HI = 8'h14;
  // control register fields
  localparam int CTRL_RUN         = 0;
  localparam int CTRL_TALK_ALWAYS = 1;
  localparam int CTRL_ADDR_LSB    = 8;
  localparam int CTRL_PPOLL_LSB   = 16;
  // status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_PTR_LSB   = 8;
  localparam int ST_LISTEN    = 12;
  localparam int ST_TALK      = 13;
  localparam int ST_REMOTE    = 14;
  localparam int ST_LOCKOUT   = 15;
  localparam int ST_READY     = 16;
  localparam int ST_SRQ       = 17;
  // control word layout
  localparam int ROM_DEPTH  = 256;
  localparam int ROM_WIDTH  = 16;
  localparam int CW_F       = 15;
  localparam int CW_INV     = 14;
  localparam int CW_SEL_LSB = 8;
  // actions of a format 0 state
  typedef enum logic [5:0] {
    OP_NOP, OP_CHAR, OP_PTR_INC, OP_PTR_CLR, OP_DIO_DRIVE, OP_DIO_REL,
    OP_DAV_SET, OP_DAV_CLR, OP_NRFD_SET, OP_NRFD_CLR, OP_NDAC_SET, OP_NDAC_CLR,
    OP_RX_LATCH, OP_CMD_DECODE, OP_STORE, OP_MODULE_WR, OP_SRQ_SET, OP_SRQ_CLR,
    OP_READING_DONE, OP_FLAG_SET, OP_FLAG_CLR
  } op_e;
  // qualifier bit positions
  localparam int Q_ATN       = 8;
  localparam int Q_READY     = 15;
  localparam int Q_LAST_CHAR = 21;
  localparam int Q_FLAG_LSB  = 24;
  localparam int Q_PTR_LSB   = 32;
  localparam int Q_LET_LSB   = 36;
  localparam int Q_COUNT     = 52;
  // sync vector positions of bus lines
  localparam int L_ATN = 8;
  localparam int L_DAV = 9;
  localparam int L_NRFD = 10;
  localparam int L_NDAC = 11;
  localparam int L_IFC = 12;
  localparam int L_REN = 13;
  localparam int L_EOI = 14;
  // output string
  localparam int IDX_OVF  = 0;
  localparam int IDX_SIGN = 1;
  localparam int IDX_MANT = 2;
  localparam int MANT_DIG = 9;
  localparam int IDX_EXPL = 11;
  localparam int IDX_EXP  = 12;
  localparam int IDX_CR   = 13;
  localparam logic [3:0] IDX_LF = 4'he;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_PLUS  = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_E     = 8'h45;
  localparam logic [7:0] CH_O     = 8'h4f;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_LF    = 8'h0a;
  localparam logic [3:0] CH_DIGIT = 4'h3;
  // bus commands, seven bits
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK   = 2'h2;
  localparam logic [4:0] ADDR_NONE  = 5'h1f;
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  // program letters: p q u r t f g a b c d s
  localparam logic [11:0][7:0] LETTERS = {8'h53, 8'h44, 8'h43, 8'h42, 8'h41,
    8'h47, 8'h46, 8'h54, 8'h52, 8'h55, 8'h51, 8'h50};
endpackage : iface_pkg

// file: rtl/ieee488_rom_sequencer_interface.sv
// microcoded instrument bus interface controller with apb access
//
// Summary of operation
// - 256 state sequencer, 256x16 microcode words
// - format zero acts, then steps to next
// - format one branches on selected qualifier
// - jump only on format one, qualifier low
// - each format one state selects one of 52 qualifiers
// - control bit inverts selected qualifier
// - same state group runs per output character
// - pointer steps per character, selects character
// - nine digit mantissa, blank leading zeros, exponent
// - overflow, sign, then carriage return, linefeed
// - listener loads mainframe and module storage
// - service request line driven low on demand
// - bytes move parallel, paced by handshake
// - attention low monitors, else only addressed
// - foreign talk address clears own talker
// - data valid waits for ready, accepted release waits for valid
// - commands use seven data bits
// - data bytes use eight bits
// - interface clear forces quiescent state
// - remote enable with commands picks remote
// - talker asserts end line on last byte
// - attention with end line gives poll status
// - attention bytes decoded as bus commands
`timescale 1ns/1ns
module ieee488_rom_sequencer_interface (
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        cen,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // instrument bus data lines, open drain
  input  wire logic [7:0]  dio_i,
  output logic      [7:0]  dio_o,
  output logic      [7:0]  dio_oe_n,
  // instrument bus control lines
  input  wire logic        atn_i,
  input  wire logic        ifc_i,
  input  wire logic        ren_i,
  input  wire logic        dav_i,
  output logic             dav_o,
  output logic             dav_oe_n,
  input  wire logic        nrfd_i,
  output logic             nrfd_o,
  output logic             nrfd_oe_n,
  input  wire logic        ndac_i,
  output logic             ndac_o,
  output logic             ndac_oe_n,
  input  wire logic        eoi_i,
  output logic             eoi_o,
  output logic             eoi_oe_n,
  output logic             srq_o,
  output logic             srq_oe_n,
  // mainframe reading
  input  wire logic        reading_valid,
  input  wire logic [35:0] reading_mant,
  input  wire logic [3:0]  reading_exp,
  input  wire logic        reading_neg,
  input  wire logic        reading_ovf,
  // mainframe and module programming
  output logic      [63:0] ctrl_store,
  output logic             module_wr,
  output logic      [7:0]  module_addr,
  output logic      [7:0]  module_data,
  output logic             trigger,
  output logic             remote,
  output logic             lockout
);

  typedef struct packed {
    logic [iface_pkg::ROM_DEPTH-1:0][iface_pkg::ROM_WIDTH-1:0] microcode_rom;
    logic [7:0]       rom_addr;
    logic [31:0]      ctrl;
    logic [31:0]      prdata;
    logic [3:0]       next_state_counter_high;
    logic [3:0]       next_state_counter_low;
    logic [3:0]       character_pointer;
    logic [14:0]      sync1;
    logic [14:0]      sync2;
    logic [7:0]       rx;
    logic [7:0]       tx;
    logic             dio_drv;
    logic [7:0]       dio_en;
    logic             dav_en;
    logic             nrfd_en;
    logic             ndac_en;
    logic             eoi_en;
    logic             srq_en;
    logic             listen;
    logic             talk;
    logic             remote;
    logic             lockout;
    logic             ready;
    logic [35:0]      mant;
    logic [3:0]       expo;
    logic             neg;
    logic             ovf;
    logic [7:0]       flags;
    logic [7:0][7:0]  store;
    logic             module_wr;
    logic [7:0]       module_addr;
    logic [7:0]       module_data;
    logic             trigger;
  } st_s;

  st_s                          q;
  st_s                          d;
  logic [14:0]                  line;
  logic [15:0]                  cw;
  logic [5:0]                   sel;
  logic                         qual;
  logic [iface_pkg::Q_COUNT-1:0] qv;
  logic [4:0]                   my_addr;
  logic [2:0]                   ppoll_line;
  logic                         talk_always;
  logic [15:0][7:0]             chars;
  logic                         lead;
  logic                         blank;
  logic [3:0]                   dig;
  logic [4:0]                   low_sum;
  logic                         access;
  logic                         mapped;
  logic [31:0]                  rdata;
  logic [6:0]                   cmd;

  // asserted bus lines are low; the synced copy is inverted once here
  assign line        = ~q.sync2;
  assign my_addr     = q.ctrl[iface_pkg::CTRL_ADDR_LSB +: 5];
  assign ppoll_line  = q.ctrl[iface_pkg::CTRL_PPOLL_LSB +: 3];
  assign talk_always = q.ctrl[iface_pkg::CTRL_TALK_ALWAYS];
  assign cw          = q.microcode_rom[{q.next_state_counter_high,
                                        q.next_state_counter_low}];
  assign sel         = cw[iface_pkg::CW_SEL_LSB +: 6];
  assign cmd         = q.rx[6:0];

  // qualifier vector, 52 condition bits
  always_comb begin
    qv = '0;
    qv[7:0] = line[7:0];
    qv[iface_pkg::Q_ATN +: 7] = line[14:8];
    qv[iface_pkg::Q_READY] = q.ready;
    qv[16] = q.listen;
    qv[17] = q.talk;
    qv[18] = q.remote;
    qv[19] = q.lockout;
    qv[20] = talk_always;
    qv[iface_pkg::Q_LAST_CHAR] = (q.character_pointer == iface_pkg::IDX_LF);
    qv[22] = (q.rx[7:4] == iface_pkg::CH_DIGIT) && (q.rx[3:0] < 4'ha);
    qv[23] = (q.rx >= 8'h41) && (q.rx <= 8'h5a);
    qv[iface_pkg::Q_FLAG_LSB +: 8] = q.flags;
    qv[iface_pkg::Q_PTR_LSB +: 4] = q.character_pointer;
    for (int i = 0; i < 12; i++) begin
      qv[iface_pkg::Q_LET_LSB + i] = (q.rx == iface_pkg::LETTERS[i]);
    end
    qv[48] = (cmd == {iface_pkg::GRP_LISTEN, my_addr});
    qv[49] = (cmd == {iface_pkg::GRP_TALK, my_addr});
    qv[50] = (cmd == {iface_pkg::GRP_LISTEN, iface_pkg::ADDR_NONE});
    qv[51] = (cmd == {iface_pkg::GRP_TALK, iface_pkg::ADDR_NONE});
  end

  // selected qualifier with optional inversion
  assign qual = ((sel < 6'(iface_pkg::Q_COUNT)) ? qv[sel] : 1'b0)
                ^ cw[iface_pkg::CW_INV];

  // output string: overflow, sign, mantissa, e, exponent, cr, lf
  always_comb begin
    chars = {16{iface_pkg::CH_SPACE}};
    lead  = 1'b1;
    blank = 1'b0;
    dig   = 4'h0;
    chars[iface_pkg::IDX_OVF]  = q.ovf ? iface_pkg::CH_O : iface_pkg::CH_SPACE;
    chars[iface_pkg::IDX_SIGN] = q.neg ? iface_pkg::CH_MINUS : iface_pkg::CH_PLUS;
    for (int i = 0; i < iface_pkg::MANT_DIG; i++) begin
      dig   = q.mant[35 - 4 * i -: 4];
      blank = lead && (dig == 4'h0) && (i != iface_pkg::MANT_DIG - 1);
      lead  = blank;
      chars[iface_pkg::IDX_MANT + i] = blank ? iface_pkg::CH_SPACE
                                             : {iface_pkg::CH_DIGIT, dig};
    end
    chars[iface_pkg::IDX_EXPL] = iface_pkg::CH_E;
    chars[iface_pkg::IDX_EXP]  = {iface_pkg::CH_DIGIT, q.expo};
    chars[iface_pkg::IDX_CR]   = iface_pkg::CH_CR;
    chars[iface_pkg::IDX_LF]   = iface_pkg::CH_LF;
  end

  // apb decode and read mux
  assign access = psel && penable;
  always_comb begin
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    case (paddr)
      iface_pkg::REG_CTRL: begin
        rdata = q.ctrl;
      end
      iface_pkg::REG_STATUS: begin
        rdata[iface_pkg::ST_STATE_LSB +: 8] = {q.next_state_counter_high,
                                              q.next_state_counter_low};
        rdata[iface_pkg::ST_PTR_LSB +: 4] = q.character_pointer;
        rdata[iface_pkg::ST_LISTEN]  = q.listen;
        rdata[iface_pkg::ST_TALK]    = q.talk;
        rdata[iface_pkg::ST_REMOTE]  = q.remote;
        rdata[iface_pkg::ST_LOCKOUT] = q.lockout;
        rdata[iface_pkg::ST_READY]   = q.ready;
        rdata[iface_pkg::ST_SRQ]     = q.srq_en;
      end
      iface_pkg::REG_ROM_ADDR: begin
        rdata[7:0] = q.rom_addr;
      end
      iface_pkg::REG_ROM_DATA: begin
        rdata[15:0] = q.microcode_rom[q.rom_addr];
      end
      iface_pkg::REG_STORE_LO: begin
        rdata = {q.store[3], q.store[2], q.store[1], q.store[0]};
      end
      iface_pkg::REG_STORE_HI: begin
        rdata = {q.store[7], q.store[6], q.store[5], q.store[4]};
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // next state of everything
  always_comb begin
    d = q;
    d.module_wr = 1'b0;
    d.trigger   = 1'b0;
    // two stage synchronisers for all bus lines
    d.sync1 = {eoi_i, ren_i, ifc_i, ndac_i, nrfd_i, dav_i, atn_i, dio_i};
    d.sync2 = q.sync1;
    low_sum = {1'b0, q.next_state_counter_low} + 5'h01;

    // register access; read data captured in setup phase
    if (psel && !penable) begin
      d.prdata = rdata;
    end
    if (access && mapped) begin
      if (paddr == iface_pkg::REG_ROM_DATA) begin
        d.rom_addr = q.rom_addr + 8'h01;
      end
      if (pwrite) begin
        case (paddr)
          iface_pkg::REG_CTRL: begin
            d.ctrl = pwdata;
          end
          iface_pkg::REG_ROM_ADDR: begin
            d.rom_addr = pwdata[7:0];
          end
          iface_pkg::REG_ROM_DATA: begin
            d.microcode_rom[q.rom_addr] = pwdata[15:0];
          end
          default: begin
          end
        endcase
      end
    end

    // sequencer stepping
    if (q.ctrl[iface_pkg::CTRL_RUN]) begin
      if (cw[iface_pkg::CW_F] && !qual) begin
        {d.next_state_counter_high, d.next_state_counter_low} = cw[7:0];
      end else begin
        d.next_state_counter_low  = low_sum[3:0];
        d.next_state_counter_high = q.next_state_counter_high + {3'h0, low_sum[4]};
      end
      if (!cw[iface_pkg::CW_F]) begin
        case (iface_pkg::op_e'(cw[iface_pkg::CW_SEL_LSB +: 6]))
          iface_pkg::OP_CHAR: begin
            d.tx     = chars[q.character_pointer];
            d.eoi_en = (q.character_pointer == iface_pkg::IDX_LF);
          end
          iface_pkg::OP_PTR_INC: begin
            d.character_pointer = q.character_pointer + 4'h1;
          end
          iface_pkg::OP_PTR_CLR: begin
            d.character_pointer = 4'h0;
          end
          iface_pkg::OP_DIO_DRIVE: begin
            d.dio_drv = (q.talk || talk_always) && !line[iface_pkg::L_ATN];
          end
          iface_pkg::OP_DIO_REL: begin
            d.dio_drv = 1'b0;
            d.eoi_en  = 1'b0;
          end
          iface_pkg::OP_DAV_SET: begin
            // data valid only once no listener holds not ready
            d.dav_en = q.dio_drv && !line[iface_pkg::L_NRFD];
          end
          iface_pkg::OP_DAV_CLR: begin
            d.dav_en = 1'b0;
          end
          iface_pkg::OP_NRFD_SET: begin
            d.nrfd_en = 1'b1;
          end
          iface_pkg::OP_NRFD_CLR: begin
            d.nrfd_en = 1'b0;
          end
          iface_pkg::OP_NDAC_SET: begin
            d.ndac_en = 1'b1;
          end
          iface_pkg::OP_NDAC_CLR: begin
            d.ndac_en = !line[iface_pkg::L_DAV];
          end
          iface_pkg::OP_RX_LATCH: begin
            if (line[iface_pkg::L_ATN] || q.listen) begin
              d.rx = line[7:0];
            end
          end
          iface_pkg::OP_CMD_DECODE: begin
            if (line[iface_pkg::L_ATN]) begin
              if (cmd == {iface_pkg::GRP_LISTEN, my_addr}) begin
                d.listen = 1'b1;
                d.remote = line[iface_pkg::L_REN];
              end
              if (cmd == {iface_pkg::GRP_LISTEN, iface_pkg::ADDR_NONE}) begin
                d.listen = 1'b0;
              end
              if (cmd == {iface_pkg::GRP_TALK, my_addr}) begin
                d.talk = 1'b1;
              end else if (cmd[6:5] == iface_pkg::GRP_TALK) begin
                d.talk = 1'b0;
              end
              if (cmd == iface_pkg::CMD_GTL && q.listen) begin
                d.remote = 1'b0;
              end
              if (cmd == iface_pkg::CMD_LLO) begin
                d.lockout = 1'b1;
              end
              if (cmd == iface_pkg::CMD_DCL ||
                  (cmd == iface_pkg::CMD_SDC && q.listen)) begin
                d.store = '0;
              end
              if (cmd == iface_pkg::CMD_GET && q.listen) begin
                d.trigger = 1'b1;
              end
            end
          end
          iface_pkg::OP_STORE: begin
            d.store[cw[2:0]] = q.rx;
          end
          iface_pkg::OP_MODULE_WR: begin
            d.module_wr   = 1'b1;
            d.module_addr = cw[7:0];
            d.module_data = q.rx;
          end
          iface_pkg::OP_SRQ_SET: begin
            d.srq_en = 1'b1;
          end
          iface_pkg::OP_SRQ_CLR: begin
            d.srq_en = 1'b0;
          end
          iface_pkg::OP_READING_DONE: begin
            d.ready = 1'b0;
          end
          iface_pkg::OP_FLAG_SET: begin
            d.flags[cw[2:0]] = 1'b1;
          end
          iface_pkg::OP_FLAG_CLR: begin
            d.flags[cw[2:0]] = 1'b0;
          end
          default: begin
          end
        endcase
      end
    end

    // a new reading wins over its clear in the same cycle
    if (reading_valid) begin
      d.mant  = reading_mant;
      d.expo  = reading_exp;
      d.neg   = reading_neg;
      d.ovf   = reading_ovf;
      d.ready = 1'b1;
    end

    // live bus: a foreign talk address unaddresses this talker
    if (line[iface_pkg::L_ATN] && line[iface_pkg::L_DAV] &&
        line[6:5] == iface_pkg::GRP_TALK && line[4:0] != my_addr) begin
      d.talk = 1'b0;
    end
    // attention stops data output at once
    if (line[iface_pkg::L_ATN]) begin
      d.dio_drv = 1'b0;
      d.eoi_en  = 1'b0;
    end
    // remote enable released drops remote and lockout
    if (!line[iface_pkg::L_REN]) begin
      d.remote  = 1'b0;
      d.lockout = 1'b0;
    end
    // interface clear: quiet bus, unaddressed, microcode restarts
    if (line[iface_pkg::L_IFC]) begin
      d.listen  = 1'b0;
      d.talk    = 1'b0;
      d.dio_drv = 1'b0;
      d.dav_en  = 1'b0;
      d.nrfd_en = 1'b0;
      d.ndac_en = 1'b0;
      d.eoi_en  = 1'b0;
      d.next_state_counter_high = 4'h0;
      d.next_state_counter_low  = 4'h0;
      d.character_pointer       = 4'h0;
    end

    // data line enables: parallel poll overrides talker output
    if (line[iface_pkg::L_ATN] && line[iface_pkg::L_EOI]) begin
      d.dio_en = q.srq_en ? (8'h01 << ppoll_line) : 8'h00;
    end else if (d.dio_drv) begin
      d.dio_en = d.tx;
    end else begin
      d.dio_en = 8'h00;
    end
  end

  // state register, frozen while cen is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else if (cen) begin
      q <= d;
    end
  end

  // apb outputs
  assign prdata  = q.prdata;
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // open drain bus pins: level always low, enable active low
  assign dio_o     = 8'h00;
  assign dio_oe_n  = ~q.dio_en;
  assign dav_o     = 1'b0;
  assign dav_oe_n  = ~q.dav_en;
  assign nrfd_o    = 1'b0;
  assign nrfd_oe_n = ~q.nrfd_en;
  assign ndac_o    = 1'b0;
  assign ndac_oe_n = ~q.ndac_en;
  assign eoi_o     = 1'b0;
  assign eoi_oe_n  = ~q.eoi_en;
  assign srq_o     = 1'b0;
  assign srq_oe_n  = ~q.srq_en;

  // mainframe side
  assign ctrl_store  = q.store;
  assign module_wr   = q.module_wr;
  assign module_addr = q.module_addr;
  assign module_data = q.module_data;
  assign trigger     = q.trigger;
  assign remote      = q.remote;
  assign lockout     = q.lockout;

endmodule : ieee488_rom_sequencer_interface

// file: tb/bus_controller_model.sv
// behavioural bus controller resolving the open drain lines
`timescale 1ns/1ns
module bus_controller_model (
  // bench requests, high = assert
  input wire logic       atn_req,
  input wire logic       eoi_req,
  input wire logic       ifc_req,
  input wire logic       ren_req,
  input wire logic [7:0] dio_req,
  // device enables, low = pulling low
  input wire logic [7:0] dio_oe_n,
  input wire logic       dav_oe_n,
  input wire logic       nrfd_oe_n,
  input wire logic       ndac_oe_n,
  input wire logic       eoi_oe_n,
  // resolved line levels, pull-up when released
  output logic     [7:0] dio_i,
  output logic           atn_i,
  output logic           ifc_i,
  output logic           ren_i,
  output logic           dav_i,
  output logic           nrfd_i,
  output logic           ndac_i,
  output logic           eoi_i
);
  // wired and of all drivers
  assign dio_i  = dio_oe_n & ~dio_req;
  assign dav_i  = dav_oe_n;
  assign nrfd_i = nrfd_oe_n;
  assign ndac_i = ndac_oe_n;
  assign atn_i  = !atn_req;
  assign ifc_i  = !ifc_req;
  assign ren_i  = !ren_req;
  assign eoi_i  = eoi_oe_n && !eoi_req;
endmodule : bus_controller_model

// file: tb/ieee488_rom_sequencer_interface_assertions.sv
// checker on the ports of the bus interface controller
`timescale 1ns/1ns
module ieee488_rom_sequencer_interface_assertions (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb side
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // bus lines
  input wire logic        atn_i,
  input wire logic        ifc_i,
  input wire logic        ren_i,
  input wire logic        eoi_i,
  input wire logic [7:0]  dio_oe_n,
  input wire logic        dav_oe_n,
  input wire logic        eoi_oe_n,
  // mainframe side
  input wire logic        remote,
  input wire logic        lockout,
  input wire logic        trigger
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // line held long enough to pass the synchroniser
  sequence s_ifc_held;
    (!ifc_i && eoi_i) [*3];
  endsequence
  sequence s_atn_cmd;
    (!atn_i && eoi_i) [*3];
  endsequence
  sequence s_poll;
    (!atn_i && !eoi_i) [*3];
  endsequence
  logic unmapped;
  // offsets outside the register map
  assign unmapped = (paddr > 8'h14) || (paddr[1:0] != 2'h0);
  a_slverr_unmapped: assert property (psel && penable |-> pslverr == unmapped)
    else $error("slave error does not match address");
  a_rdata_setup: assert property ($changed(prdata) |-> $past(psel && !penable))
    else $error("read data changed outside setup");
  a_ifc_quiet: assert property (s_ifc_held |=> dio_oe_n == 8'hff && dav_oe_n && eoi_oe_n)
    else $error("bus drive kept during interface clear");
  a_atn_eoi_rel: assert property (s_atn_cmd |=> eoi_oe_n)
    else $error("end line driven while attention held");
  a_ren_local: assert property (ren_i [*3] |=> !remote && !lockout)
    else $error("remote kept without remote enable");
  a_trig_pulse: assert property (trigger |=> !trigger)
    else $error("trigger longer than one cycle");
  a_reset_quiet: assert property ($rose(presetn) |-> dio_oe_n == 8'hff && dav_oe_n)
    else $error("bus driven right after reset");
  a_poll_one: assert property (s_poll |=> $countones(~dio_oe_n) <= 1)
    else $error("poll drives more than one data line");
endmodule : ieee488_rom_sequencer_interface_assertions

// file: tb/tb_ieee488_rom_sequencer_interface.sv
// self-checking bench for the bus interface controller
`timescale 1ns/1ns
module tb_ieee488_rom_sequencer_interface;
  logic        pclk, presetn, cen, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, dio_i, dio_oe_n, j, dio_req;
  logic [31:0] pwdata, prdata, rd;
  logic        atn_i, ifc_i, ren_i, dav_i, nrfd_i, ndac_i, eoi_i, err, ta;
  logic        dav_oe_n, nrfd_oe_n, ndac_oe_n, eoi_oe_n, srq_oe_n;
  logic        atn_req, eoi_req, ifc_req, ren_req, reading_valid;
  logic        reading_neg, reading_ovf, remote, lockout, trigger;
  logic [35:0] reading_mant;
  logic [3:0]  reading_exp;
  logic [15:0] w;
  int          num_errors = 0;
  int          checked = 0;
  // design and far side
  ieee488_rom_sequencer_interface u_ieee488_rom_sequencer_interface (.pclk, .presetn, .cen,
    .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .dio_i,
    .dio_o(), .dio_oe_n, .atn_i, .ifc_i, .ren_i, .dav_i, .dav_o(), .dav_oe_n, .nrfd_i,
    .nrfd_o(), .nrfd_oe_n, .ndac_i, .ndac_o(), .ndac_oe_n, .eoi_i, .eoi_o(), .eoi_oe_n,
    .srq_o(), .srq_oe_n, .reading_valid, .reading_mant, .reading_exp, .reading_neg,
    .reading_ovf, .ctrl_store(), .module_wr(), .module_addr(), .module_data(), .trigger,
    .remote, .lockout);
  bus_controller_model u_bus_controller_model (.atn_req, .eoi_req, .ifc_req, .ren_req, .dio_req,
    .dio_oe_n, .dav_oe_n, .nrfd_oe_n, .ndac_oe_n, .eoi_oe_n, .dio_i, .atn_i, .ifc_i,
    .ren_i, .dav_i, .nrfd_i, .ndac_i, .eoi_i);
  // clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // expected status: state and pointer
  function automatic logic [31:0] exp_stat(input logic t, input logic [7:0] jp);
    return t ? 32'h103 : {24'h0, jp};
  endfunction : exp_stat
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, waits for pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rom(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, iface_pkg::REG_ROM_ADDR, {24'h0, a});
    apb(1'b1, iface_pkg::REG_ROM_DATA, {16'h0, d});
  endtask : rom
  // stop, clear the interface, expect state zero
  task automatic restart();
    apb(1'b1, iface_pkg::REG_CTRL, 32'h0);
    ifc_req <= 1'b1;
    repeat (4) @(posedge pclk);
    ifc_req <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b0, iface_pkg::REG_STATUS, 32'h0);
    chk(rd & 32'hfff, 32'h0);
  endtask : restart
  task automatic stop_test();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  // watchdog
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, reading_valid} = '0;
    {atn_req, eoi_req, ifc_req, ren_req, reading_neg, reading_ovf} = '0;
    {reading_mant, reading_exp, dio_req} = '0;
    cen = 1'b1;
    rd = $urandom(4);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, iface_pkg::REG_STATUS, 32'h0);
    chk(rd & 32'hfff, 32'h0);
    reading_mant  <= 36'h000123456;
    reading_valid <= 1'b1;
    @(posedge pclk);
    reading_valid <= 1'b0;
    apb(1'b0, iface_pkg::REG_STATUS, 32'h0);
    chk({31'h0, rd[iface_pkg::ST_READY]}, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    // microcode word readback, address post increment
    j = 8'($urandom_range(239, 16));
    w = 16'($urandom);
    rom(j, w);
    apb(1'b0, iface_pkg::REG_ROM_ADDR, 32'h0);
    chk(rd, {24'h0, 8'(j + 8'h1)});
    apb(1'b1, iface_pkg::REG_ROM_ADDR, {24'h0, j});
    apb(1'b0, iface_pkg::REG_ROM_DATA, 32'h0);
    chk(rd, {16'h0, w});
    // branch on talk always, taken and not taken
    repeat (4) begin
      j  = 8'($urandom_range(239, 16));
      ta = 1'($urandom_range(1, 0));
      restart();
      rom(8'h0, {8'h94, j});
      rom(8'h1, 16'hf400);
      rom(8'h2, 16'h0200);
      rom(8'h3, 16'hb403);
      rom(j, {8'hb4, j});
      apb(1'b1, iface_pkg::REG_CTRL, {30'h0, ta, 1'b1});
      repeat (30) @(posedge pclk);
      apb(1'b0, iface_pkg::REG_STATUS, 32'h0);
      chk(rd & 32'hfff, exp_stat(ta, j));
    end
    // service request then parallel poll on line 3
    restart();
    rom(8'h0, 16'h1000);
    rom(8'h1, 16'hb401);
    apb(1'b1, iface_pkg::REG_CTRL, 32'h0003_0001);
    repeat (10) @(posedge pclk);
    chk({31'h0, srq_oe_n}, 32'h0);
    atn_req <= 1'b1;
    eoi_req <= 1'b1;
    repeat (5) @(posedge pclk);
    chk({24'h0, dio_oe_n}, 32'hf7);
    eoi_req <= 1'b0;
    repeat (5) @(posedge pclk);
    chk({24'h0, dio_oe_n}, 32'hff);
    atn_req <= 1'b0;
    // listener, lockout, trigger
    restart();
    rom(8'h0, 16'h0c00);
    rom(8'h1, 16'h0d00);
    rom(8'h2, 16'hb400);
    apb(1'b1, iface_pkg::REG_CTRL, 32'h0000_0501);
    {atn_req, ren_req, dio_req} <= {2'h3, 8'h25};
    repeat (12) @(posedge pclk);
    dio_req <= 8'h11;
    repeat (12) @(posedge pclk);
    chk({30'h0, remote, lockout}, 32'h3);
    dio_req <= 8'h08;
    repeat (12) @(posedge pclk);
    {atn_req, ren_req} <= 2'h0;
    repeat (6) @(posedge pclk);
    stop_test();
  end
endmodule : tb_ieee488_rom_sequencer_interface
bind ieee488_rom_sequencer_interface ieee488_rom_sequencer_interface_assertions u_chk (
  .pclk, .presetn, .paddr, .psel, .penable, .prdata, .pslverr, .atn_i, .ifc_i, .ren_i,
  .eoi_i, .dio_oe_n, .dav_oe_n, .eoi_oe_n, .remote, .lockout, .trigger);
